// file: design/pts_pkg.sv
// Constants, types and register map of the threshold stage bank
package pts_pkg;
    localparam int MAX_STAGES = 10;
    localparam int MAX_SEL = 3;
    localparam int NUM_MEAS = 8;
    localparam int SEL_W = 3;
    localparam int NUM_GROUPS = 8;
    localparam int GRP_W = 3;
    localparam int CNT_SET_W = 4;
    localparam int STG_W = 4;
    localparam int MEAS_W = 16;
    localparam int MS_W = 16;
    localparam int TS_W = 25;
    localparam int CNT_W = 16;
    localparam int NUM_SIG = 3;
    localparam int ADDR_W = 12;
    localparam int EVAL_W = 3;
    // Timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int TS_RES_MS = 1;
    localparam int TS_RES_NS = TS_RES_MS * 1000000;
    localparam int MS_CYC = TS_RES_NS / CLK_PERIOD_NS;
    localparam int EVAL_PERIOD_MS = 5;
    localparam int EVAL_TICKS = EVAL_PERIOD_MS / TS_RES_MS;
    // Register map
    localparam logic [ADDR_W-1:0] REG_CTRL = 12'h000;
    localparam logic [ADDR_W-1:0] REG_STATUS = 12'h004;
    localparam logic [ADDR_W-1:0] REG_INT_STAT = 12'h008;
    localparam logic [ADDR_W-1:0] REG_INT_CLR = 12'h00C;
    localparam logic [ADDR_W-1:0] REG_INT_EN = 12'h010;
    localparam logic [ADDR_W-1:0] REG_CNT_CLR = 12'h014;
    localparam logic [ADDR_W-1:0] REG_EVT = 12'h018;
    localparam logic [ADDR_W-1:0] REG_EVT_FILL = 12'h01C;
    localparam logic [ADDR_W-1:0] REG_SEL = 12'h020;
    localparam logic [ADDR_W-1:0] REG_INFO = 12'h024;
    localparam logic [ADDR_W-1:0] REG_TIME = 12'h028;
    localparam logic [ADDR_W-1:0] SET_BASE = 12'h100;
    localparam int SET_SH = 3;
    localparam int SET_WORD_BIT = 2;
    localparam logic [ADDR_W-1:0] SET_END =
        SET_BASE + ADDR_W'((NUM_GROUPS * MAX_STAGES) << SET_SH);
    localparam logic [ADDR_W-1:0] CNT_BASE = 12'h400;
    localparam int CNT_SH = 2;
    localparam logic [ADDR_W-1:0] CNT_END =
        CNT_BASE + ADDR_W'((MAX_STAGES * NUM_SIG) << CNT_SH);
    // Fields
    localparam int CTRL_ACT_BIT = 0;
    localparam int CTRL_CNT_LSB = 8;
    localparam int CTRL_GRP_LSB = 16;
    localparam logic [CNT_SET_W-1:0] STAGE_CNT_RST = 4'h1;
    localparam logic [CNT_SET_W-1:0] STAGE_CNT_MIN = 4'h1;
    localparam logic [CNT_SET_W-1:0] STAGE_CNT_MAX = 4'hA;
    localparam logic [31:0] CFG_MASK = 32'h0000_7FFF;
    localparam int INT_W = 4;
    localparam int INT_START = 0;
    localparam int INT_TRIP = 1;
    localparam int INT_INHIB = 2;
    localparam int INT_OVF = 3;
    localparam int SIG_START = 0;
    localparam int SIG_TRIP = 1;
    localparam int SIG_INHIB = 2;

    typedef logic signed [MEAS_W-1:0] pts_meas_t;
    typedef enum logic [1:0] {
        above_limit_pickup,
        below_limit_pickup,
        rate_limit_pickup
    } pts_crit_t;
    typedef enum logic [2:0] {
        cond_disabled,
        cond_idle,
        cond_started,
        cond_tripped,
        cond_inhibited
    } pts_cond_t;
    typedef struct packed {
        logic [16:0] rsvd;
        logic [MAX_SEL-1:0][SEL_W-1:0] sel;
        logic [1:0] nsel;
        logic definite_time_delay;
        pts_crit_t crit;
        logic stage_enable;
    } pts_cfg_t;
    typedef struct packed {
        logic [MS_W-1:0] delay_ms;
        pts_meas_t limit;
    } pts_lim_t;
    typedef struct packed {
        logic [TS_W-1:0] ts;
        logic [STG_W-1:0] stage;
        logic [1:0] sig;
        logic on;
    } pts_evt_t;
endpackage

// file: design/pts_tick.sv
// Millisecond and evaluation-cycle tick divider with timestamp counter
`timescale 1ns/10ps
module pts_tick
    import pts_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    output logic tick_ms,
    output logic tick_eval,
    output logic [TS_W-1:0] ts_ms
);
    localparam int CW = $clog2(MS_CYCLES);
    localparam logic [CW-1:0] MS_LAST = CW'(MS_CYCLES - 1);
    localparam logic [EVAL_W-1:0] EV_LAST = EVAL_W'(EVAL_TICKS - 1);

    logic [CW-1:0] div_r, div_nxt;
    logic [EVAL_W-1:0] ev_r, ev_nxt;
    logic [TS_W-1:0] ts_r, ts_nxt;
    logic ms_r, ms_nxt, eval_r, eval_nxt;

    always_comb begin
        div_nxt = div_r + 1'b1;
        ev_nxt = ev_r;
        ts_nxt = ts_r;
        ms_nxt = 1'b0;
        eval_nxt = 1'b0;
        if (div_r == MS_LAST) begin
            div_nxt = '0;
            ms_nxt = 1'b1;
            ts_nxt = ts_r + 1'b1;
            ev_nxt = ev_r + 1'b1;
            if (ev_r == EV_LAST) begin
                ev_nxt = '0;
                eval_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= '0;
            ev_r <= '0;
            ts_r <= '0;
            ms_r <= 1'b0;
            eval_r <= 1'b0;
        end else begin
            div_r <= div_nxt;
            ev_r <= ev_nxt;
            ts_r <= ts_nxt;
            ms_r <= ms_nxt;
            eval_r <= eval_nxt;
        end
    end

    assign tick_ms = ms_r;
    assign tick_eval = eval_r;
    assign ts_ms = ts_r;
endmodule

// file: design/pts_user_threshold_stage.sv
// One programmable threshold stage: pick-up, delay, outputs, condition
`timescale 1ns/10ps
module pts_user_threshold_stage
    import pts_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tick_ms,
    input wire logic tick_eval,
    input wire logic active,
    input wire logic block_in,
    input wire pts_cfg_t cfg,
    input wire pts_lim_t lim,
    input wire pts_meas_t [MAX_SEL-1:0] meas,
    output logic start,
    output logic trip,
    output logic inhib,
    output pts_cond_t stage_condition,
    output logic [MS_W-1:0] op_ms,
    output logic [MS_W-1:0] remain_ms
);
    logic start_r, start_nxt, trip_r, trip_nxt, inhib_r, inhib_nxt;
    logic [MS_W-1:0] el_r, el_nxt;
    pts_meas_t [MAX_SEL-1:0] prev_r, prev_nxt;
    logic pk;
    logic [1:0] nsel_eff;

    function automatic logic meets(pts_crit_t c, pts_meas_t v, pts_meas_t p,
                                   pts_meas_t l);
        logic signed [MEAS_W:0] d;
        d = $signed({v[MEAS_W-1], v}) - $signed({p[MEAS_W-1], p});
        if (d < 0) begin
            d = -d;
        end
        case (c)
            above_limit_pickup: meets = v > l;
            below_limit_pickup: meets = v < l;
            default: meets = d >= $signed({l[MEAS_W-1], l});
        endcase
    endfunction

    always_comb begin
        nsel_eff = (cfg.nsel == 2'h0) ? 2'h1 : cfg.nsel;
        pk = 1'b0;
        for (int i = 0; i < MAX_SEL; i++) begin
            if (i < int'(nsel_eff) && meets(cfg.crit, meas[i], prev_r[i], lim.limit)) begin
                pk = 1'b1;
            end
        end
        start_nxt = start_r;
        trip_nxt = trip_r;
        inhib_nxt = inhib_r;
        prev_nxt = prev_r;
        el_nxt = el_r;
        // Saturate so a very long pick-up never wraps back below the delay
        if (tick_ms && start_r && el_r != '1) begin
            el_nxt = el_r + 1'b1;
        end
        if (tick_eval) begin
            prev_nxt = meas;
            start_nxt = active && pk;
            inhib_nxt = active && pk && block_in;
            if (!start_nxt) begin
                el_nxt = '0;
            end
            if (!cfg.definite_time_delay) begin
                trip_nxt = start_nxt && !block_in;
            end else begin
                trip_nxt = start_nxt && !block_in && el_nxt >= lim.delay_ms;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_r <= 1'b0;
            trip_r <= 1'b0;
            inhib_r <= 1'b0;
            el_r <= '0;
            prev_r <= '0;
        end else begin
            start_r <= start_nxt;
            trip_r <= trip_nxt;
            inhib_r <= inhib_nxt;
            el_r <= el_nxt;
            prev_r <= prev_nxt;
        end
    end

    assign start = start_r;
    assign trip = trip_r;
    assign inhib = inhib_r;
    assign op_ms = (active && cfg.definite_time_delay) ? lim.delay_ms : '0;
    assign remain_ms = (active && cfg.definite_time_delay && lim.delay_ms > el_r) ?
        lim.delay_ms - el_r : '0;

    always_comb begin
        if (!active) begin
            stage_condition = cond_disabled;
        end else if (inhib_r) begin
            stage_condition = cond_inhibited;
        end else if (trip_r) begin
            stage_condition = cond_tripped;
        end else if (start_r) begin
            stage_condition = cond_started;
        end else begin
            stage_condition = cond_idle;
        end
    end
endmodule

// file: design/pts_stage_bank.sv
// Top of the programmable threshold stage bank with APB registers
`timescale 1ns/10ps
module pts_stage_bank
    import pts_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYC,
    parameter int EVT_DEPTH = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire pts_meas_t [NUM_MEAS-1:0] meas_in,
    input wire logic [MAX_STAGES-1:0] block_in,
    output logic [MAX_STAGES-1:0] stage_start,
    output logic [MAX_STAGES-1:0] stage_trip,
    output logic [MAX_STAGES-1:0] stage_output_a,
    output logic irq
);
    localparam int NOUT = MAX_STAGES * NUM_SIG;
    localparam int NSET = NUM_GROUPS * MAX_STAGES;
    localparam int EAW = $clog2(EVT_DEPTH);

    // ==========================================
    // Ticks
    logic tick_ms, tick_eval;
    logic [TS_W-1:0] ts_ms;

    pts_tick #(
        .MS_CYCLES(MS_CYCLES)
    ) u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .tick_ms(tick_ms),
        .tick_eval(tick_eval),
        .ts_ms(ts_ms)
    );

    // ==========================================
    // APB decode
    logic wr_en, rd_done, setup;
    assign wr_en = psel && penable && pwrite;
    assign rd_done = psel && penable && !pwrite;
    assign setup = psel && !penable;
    // Read data is captured in the setup cycle, so no wait state is needed
    assign pready = 1'b1;

    function automatic logic in_set(logic [ADDR_W-1:0] a);
        return a >= SET_BASE && a < SET_END;
    endfunction

    function automatic int set_idx(logic [ADDR_W-1:0] a);
        return int'((a - SET_BASE) >> SET_SH);
    endfunction

    function automatic logic in_cnt(logic [ADDR_W-1:0] a);
        return a >= CNT_BASE && a < CNT_END;
    endfunction

    function automatic int cnt_idx(logic [ADDR_W-1:0] a);
        return int'((a - CNT_BASE) >> CNT_SH);
    endfunction

    // ==========================================
    // Control and settings registers
    logic func_act_r, func_act_nxt;
    logic [CNT_SET_W-1:0] cnt_set_r, cnt_set_nxt, cnt_eff;
    logic [GRP_W-1:0] grp_r, grp_nxt;
    logic [INT_W-1:0] int_en_r, int_en_nxt;
    logic [STG_W-1:0] sel_r, sel_nxt;
    pts_cfg_t cfg_mem_r [NSET];
    pts_cfg_t cfg_nxt [NSET];
    pts_lim_t lim_mem_r [NSET];
    pts_lim_t lim_nxt [NSET];

    always_comb begin
        func_act_nxt = func_act_r;
        cnt_set_nxt = cnt_set_r;
        grp_nxt = grp_r;
        int_en_nxt = int_en_r;
        sel_nxt = sel_r;
        cfg_nxt = cfg_mem_r;
        lim_nxt = lim_mem_r;
        if (wr_en) begin
            if (paddr == REG_CTRL) begin
                func_act_nxt = pwdata[CTRL_ACT_BIT];
                cnt_set_nxt = pwdata[CTRL_CNT_LSB +: CNT_SET_W];
                grp_nxt = pwdata[CTRL_GRP_LSB +: GRP_W];
            end else if (paddr == REG_INT_EN) begin
                int_en_nxt = pwdata[INT_W-1:0];
            end else if (paddr == REG_SEL) begin
                sel_nxt = pwdata[STG_W-1:0];
            end else if (in_set(paddr)) begin
                if (paddr[SET_WORD_BIT]) begin
                    lim_nxt[set_idx(paddr)] = pts_lim_t'(pwdata);
                end else begin
                    cfg_nxt[set_idx(paddr)] = pts_cfg_t'(pwdata & CFG_MASK);
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            func_act_r <= 1'b0;
            cnt_set_r <= STAGE_CNT_RST;
            grp_r <= '0;
            int_en_r <= '0;
            sel_r <= '0;
            for (int i = 0; i < NSET; i++) begin
                cfg_mem_r[i] <= '0;
                lim_mem_r[i] <= '0;
            end
        end else begin
            func_act_r <= func_act_nxt;
            cnt_set_r <= cnt_set_nxt;
            grp_r <= grp_nxt;
            int_en_r <= int_en_nxt;
            sel_r <= sel_nxt;
            cfg_mem_r <= cfg_nxt;
            lim_mem_r <= lim_nxt;
        end
    end

    // Out-of-range counts are clamped rather than leaving every stage dark
    assign cnt_eff = (cnt_set_r < STAGE_CNT_MIN) ? STAGE_CNT_MIN :
                     (cnt_set_r > STAGE_CNT_MAX) ? STAGE_CNT_MAX : cnt_set_r;

    // ==========================================
    // Stages
    logic [NOUT-1:0] outs;
    pts_cond_t cond_a [MAX_STAGES];
    logic [MS_W-1:0] op_a [MAX_STAGES];
    logic [MS_W-1:0] rem_a [MAX_STAGES];
    int grp_base;
    assign grp_base = int'(grp_r) * MAX_STAGES;

    for (genvar s = 0; s < MAX_STAGES; s++) begin : g_stage
        pts_cfg_t cfg_s;
        pts_lim_t lim_s;
        pts_meas_t [MAX_SEL-1:0] sm;
        logic act_s;
        assign cfg_s = cfg_mem_r[grp_base + s];
        assign lim_s = lim_mem_r[grp_base + s];
        for (genvar k = 0; k < MAX_SEL; k++) begin : g_sel
            assign sm[k] = meas_in[cfg_s.sel[k]];
        end
        assign act_s = func_act_r && (s < int'(cnt_eff)) && cfg_s.stage_enable;
        pts_user_threshold_stage u_stage (
            .pclk(pclk),
            .presetn(presetn),
            .tick_ms(tick_ms),
            .tick_eval(tick_eval),
            .active(act_s),
            .block_in(block_in[s]),
            .cfg(cfg_s),
            .lim(lim_s),
            .meas(sm),
            .start(outs[s*NUM_SIG+SIG_START]),
            .trip(outs[s*NUM_SIG+SIG_TRIP]),
            .inhib(outs[s*NUM_SIG+SIG_INHIB]),
            .stage_condition(cond_a[s]),
            .op_ms(op_a[s]),
            .remain_ms(rem_a[s])
        );
        assign stage_start[s] = outs[s*NUM_SIG+SIG_START];
        assign stage_trip[s] = outs[s*NUM_SIG+SIG_TRIP];
        assign stage_output_a[s] = outs[s*NUM_SIG+SIG_INHIB];
    end

    // ==========================================
    // Event capture and buffer
    logic [NOUT-1:0] prev_r, prev_nxt, pend_r, pend_nxt, pon_r, pon_nxt;
    logic [NOUT-1:0] edges, rise;
    logic [TS_W-1:0] pts_r, pts_nxt;
    pts_evt_t evt_mem_r [EVT_DEPTH];
    pts_evt_t evt_nxt [EVT_DEPTH];
    logic [EAW:0] wp_r, wp_nxt, rp_r, rp_nxt, fill;
    logic evt_full, evt_pop, ovf_set;
    int serve;

    assign edges = outs ^ prev_r;
    assign rise = edges & outs;
    assign fill = wp_r - rp_r;
    assign evt_full = fill == (EAW+1)'(EVT_DEPTH);
    assign evt_pop = rd_done && paddr == REG_EVT && fill != '0;

    function automatic int lowest_set(logic [NOUT-1:0] v);
        int r;
        r = -1;
        for (int i = NOUT - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = i;
            end
        end
        return r;
    endfunction

    always_comb begin
        serve = lowest_set(pend_r);
        prev_nxt = outs;
        pend_nxt = pend_r;
        pon_nxt = (pon_r & ~edges) | (outs & edges);
        pts_nxt = pts_r;
        evt_nxt = evt_mem_r;
        wp_nxt = wp_r;
        rp_nxt = evt_pop ? rp_r + 1'b1 : rp_r;
        ovf_set = 1'b0;
        // Edges of one evaluation share a stamp, so start and trip match
        if (|edges) begin
            pts_nxt = ts_ms;
        end
        if (serve >= 0) begin
            pend_nxt[serve] = 1'b0;
            if (evt_full) begin
                ovf_set = 1'b1;
            end else begin
                evt_nxt[wp_r[EAW-1:0]] = '{ts: pts_r,
                                            stage: STG_W'(serve / NUM_SIG),
                                            sig: 2'(serve % NUM_SIG),
                                            on: pon_r[serve]};
                wp_nxt = wp_r + 1'b1;
            end
        end
        pend_nxt = pend_nxt | edges;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_r <= '0;
            pend_r <= '0;
            pon_r <= '0;
            pts_r <= '0;
            wp_r <= '0;
            rp_r <= '0;
            for (int i = 0; i < EVT_DEPTH; i++) begin
                evt_mem_r[i] <= '0;
            end
        end else begin
            prev_r <= prev_nxt;
            pend_r <= pend_nxt;
            pon_r <= pon_nxt;
            pts_r <= pts_nxt;
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            evt_mem_r <= evt_nxt;
        end
    end

    // ==========================================
    // Cumulative counters and interrupts
    logic [CNT_W-1:0] cnt_r [NOUT];
    logic [CNT_W-1:0] cnt_nxt [NOUT];
    logic [INT_W-1:0] int_stat_r, int_stat_nxt, int_set;

    always_comb begin
        logic [CNT_W-1:0] base;
        logic clr;
        base = '0;
        clr = 1'b0;
        for (int i = 0; i < NOUT; i++) begin
            clr = wr_en && paddr == REG_CNT_CLR && pwdata[i / NUM_SIG];
            base = clr ? '0 : cnt_r[i];
            // A count in the clearing cycle is kept, never lost
            cnt_nxt[i] = (rise[i] && base != '1) ? base + 1'b1 : base;
        end
        int_set = '0;
        for (int s = 0; s < MAX_STAGES; s++) begin
            int_set[INT_START] = int_set[INT_START] | rise[s*NUM_SIG+SIG_START];
            int_set[INT_TRIP] = int_set[INT_TRIP] | rise[s*NUM_SIG+SIG_TRIP];
            int_set[INT_INHIB] = int_set[INT_INHIB] | rise[s*NUM_SIG+SIG_INHIB];
        end
        int_set[INT_OVF] = ovf_set;
        int_stat_nxt = int_stat_r;
        if (wr_en && paddr == REG_INT_CLR) begin
            int_stat_nxt = int_stat_r & ~pwdata[INT_W-1:0];
        end
        int_stat_nxt = int_stat_nxt | int_set;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_stat_r <= '0;
            for (int i = 0; i < NOUT; i++) begin
                cnt_r[i] <= '0;
            end
        end else begin
            int_stat_r <= int_stat_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign irq = |(int_stat_r & int_en_r);

    // ==========================================
    // Read data
    logic [31:0] rdata_r, rdata_nxt;
    logic err_r, err_nxt;
    logic sel_ok;
    assign sel_ok = int'(sel_r) < MAX_STAGES;

    always_comb begin
        rdata_nxt = rdata_r;
        err_nxt = err_r;
        if (setup) begin
            rdata_nxt = '0;
            err_nxt = 1'b0;
            if (paddr == REG_CTRL) begin
                rdata_nxt[CTRL_ACT_BIT] = func_act_r;
                rdata_nxt[CTRL_CNT_LSB +: CNT_SET_W] = cnt_set_r;
                rdata_nxt[CTRL_GRP_LSB +: GRP_W] = grp_r;
            end else if (paddr == REG_STATUS) begin
                rdata_nxt[NOUT-1:0] = outs;
            end else if (paddr == REG_INT_STAT) begin
                rdata_nxt[INT_W-1:0] = int_stat_r;
            end else if (paddr == REG_INT_EN) begin
                rdata_nxt[INT_W-1:0] = int_en_r;
            end else if (paddr == REG_INT_CLR || paddr == REG_CNT_CLR) begin
                rdata_nxt = '0;
            end else if (paddr == REG_EVT) begin
                if (fill != '0) begin
                    rdata_nxt = evt_mem_r[rp_r[EAW-1:0]];
                end
            end else if (paddr == REG_EVT_FILL) begin
                rdata_nxt[EAW:0] = fill;
            end else if (paddr == REG_SEL) begin
                rdata_nxt[STG_W-1:0] = sel_r;
            end else if (paddr == REG_INFO) begin
                if (sel_ok) begin
                    rdata_nxt[2:0] = cond_a[sel_r];
                end
            end else if (paddr == REG_TIME) begin
                if (sel_ok) begin
                    rdata_nxt = {op_a[sel_r], rem_a[sel_r]};
                end
            end else if (in_set(paddr)) begin
                rdata_nxt = paddr[SET_WORD_BIT] ? lim_mem_r[set_idx(paddr)] :
                                                  cfg_mem_r[set_idx(paddr)];
            end else if (in_cnt(paddr)) begin
                rdata_nxt[CNT_W-1:0] = cnt_r[cnt_idx(paddr)];
            end else begin
                err_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_r <= '0;
            err_r <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            err_r <= err_nxt;
        end
    end

    assign prdata = rdata_r;
    assign pslverr = err_r;
endmodule

// file: sim/pts_stage_bank_chk.sv
// Port assertions for the threshold stage bank
`timescale 1ns/10ps
module pts_stage_bank_chk
    import pts_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [MAX_STAGES-1:0] block_in,
    input wire logic [MAX_STAGES-1:0] stage_start,
    input wire logic [MAX_STAGES-1:0] stage_trip,
    input wire logic [MAX_STAGES-1:0] stage_output_a
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========================================
    // Stage outputs
    property p_stab; $changed(stage_start) |=> $stable(stage_start) [*8]; endproperty
    a_stab: assert property (p_stab) else $error("start moved between ticks");
    property p_trs; (stage_trip & ~stage_start) == '0; endproperty
    a_trs: assert property (p_trs) else $error("trip without start");
    property p_tb; (stage_trip & stage_output_a) == '0; endproperty
    a_tb: assert property (p_tb) else $error("trip while stage_output_a");
    property p_bs; (stage_output_a & ~stage_start) == '0; endproperty
    a_bs: assert property (p_bs) else $error("stage_output_a without start");
    // Block input sampled at tick, so allow one extra clock
    property p_blk; $rose(stage_output_a[0]) |-> $past(block_in[0]) || $past(block_in[0], 2);
    endproperty
    a_blk: assert property (p_blk) else $error("stage_output_a with no block input");
    // ==========================================
    // Register bus
    property p_rdy; psel && penable |-> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("wait state inserted");
    property p_err; psel && !penable && paddr == 12'hFFC |=> pslverr; endproperty
    a_err: assert property (p_err) else $error("unmapped access accepted");
    property p_ok; psel && !penable && paddr == REG_CTRL |=> !pslverr; endproperty
    a_ok: assert property (p_ok) else $error("mapped access refused");
endmodule
bind pts_stage_bank pts_stage_bank_chk #(.MS_CYCLES(MS_CYCLES)) chk_u (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
    .pslverr(pslverr), .block_in(block_in), .stage_start(stage_start),
    .stage_trip(stage_trip), .stage_output_a(stage_output_a));

// file: sim/pts_stage_bank_test.sv
// Self-checking bench for the threshold stage bank
`timescale 1ns/10ps
module pts_stage_bank_test import pts_pkg::*;;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, er;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd, rd0;
    pts_meas_t [NUM_MEAS-1:0] meas_in = '0;
    logic [MAX_STAGES-1:0] block_in = '0, st, tr, bk;
    int err_total = 0, n_compared = 0;
    always #20 pclk = ~pclk;
    // Short ms tick keeps the run small: eval every 20 clocks
    pts_stage_bank #(.MS_CYCLES(4)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .meas_in(meas_in), .block_in(block_in),
        .stage_start(st), .stage_trip(tr), .stage_output_a(bk), .irq(irq));
    function logic [31:0] cfgw(logic [1:0] crit, logic dt);
        return {28'h0, dt, crit, 1'b1};
    endfunction
    task chk(string nm, logic [31:0] e, logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task rw(logic w, logic [ADDR_W-1:0] a, logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task tally_and_finish;
        $display("Compared %0d, errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge pclk);
        err_total++;
        tally_and_finish;
    end
    initial begin
        void'($urandom(32'hC58E));
        repeat (6) @(posedge pclk);
        presetn <= 1;
        rw(0, REG_CTRL, 0);
        chk("ctrl", 32'h0000_0100, rd);
        rw(0, 12'hFFC, 0);
        chk("slverr", 1, er);
        rw(1, SET_BASE, cfgw(2'h0, 1));
        rw(1, SET_BASE + 12'h004, 32'h000A_0064);
        rw(1, REG_INT_EN, 32'hF);
        rw(1, REG_CTRL, 32'h0000_0201);
        meas_in[0] <= pts_meas_t'(16'h0065 + 16'($urandom_range(999)));
        for (int i = 0; i < 100 && st[0] !== 1'b1; i++) @(posedge pclk);
        chk("start", 1, st[0]);
        repeat (25) @(posedge pclk);
        chk("early trip", 0, tr[0]);
        for (int i = 0; i < 100 && tr[0] !== 1'b1; i++) @(posedge pclk);
        chk("trip", 1, tr[0]);
        chk("irq", 1, irq);
        rw(1, REG_INT_CLR, 32'hF);
        rw(0, REG_INFO, 0);
        chk("irq clr", 0, irq);
        chk("cond0", 3, rd);
        rw(0, REG_TIME, 0);
        chk("op ms", 10, rd[31:16]);
        chk("remain", 0, rd[15:0]);
        rw(1, REG_SEL, 1);
        rw(0, REG_INFO, 0);
        chk("cond1", 0, rd);
        rw(0, REG_EVT_FILL, 0);
        chk("fill", 2, rd);
        rw(0, REG_EVT, 0);
        chk("evt start", 7'h01, rd[6:0]);
        rd0 = rd;
        rw(0, REG_EVT, 0);
        chk("evt trip", 7'h03, rd[6:0]);
        chk("evt stamp", 10, rd[31:7] - rd0[31:7]);
        rw(0, CNT_BASE + 12'h004, 0);
        chk("trip cnt", 1, rd);
        rw(1, REG_CNT_CLR, 1);
        rw(0, CNT_BASE, 0);
        chk("cnt clr", 0, rd);
        block_in[0] <= 1;
        for (int i = 0; i < 100 && bk[0] !== 1'b1; i++) @(posedge pclk);
        chk("stage_output_a", 1, bk[0]);
        chk("trip blk", 0, tr[0]);
        block_in[0] <= 0;
        meas_in[0] <= 16'h0000;
        for (int i = 0; i < 100 && st[0] !== 1'b0; i++) @(posedge pclk);
        chk("drop", 0, st[0]);
        rw(1, SET_BASE, cfgw(2'h0, 0));
        meas_in[0] <= 16'h0200;
        for (int i = 0; i < 100 && st[0] !== 1'b1; i++) @(posedge pclk);
        chk("instant", 1, tr[0]);
        rw(1, SET_BASE + 12'h008, cfgw(2'h1, 0));
        rw(1, SET_BASE + 12'h00C, 32'h0000_0300);
        for (int i = 0; i < 100 && st[1] !== 1'b1; i++) @(posedge pclk);
        chk("below", 1, st[1]);
        rw(1, SET_BASE, cfgw(2'h2, 0));
        for (int i = 0; i < 100 && st[0] !== 1'b0; i++) @(posedge pclk);
        chk("rate still", 0, st[0]);
        // Step of 0x80 beats the limit and keeps stage 1 below its limit
        meas_in[0] <= 16'h0280;
        for (int i = 0; i < 100 && st[0] !== 1'b1; i++) @(posedge pclk);
        chk("rate", 1, st[0]);
        rw(1, REG_CTRL, 32'h0001_0201);
        for (int i = 0; i < 100 && st[1] !== 1'b0; i++) @(posedge pclk);
        chk("group", 0, st[1]);
        tally_and_finish;
    end
endmodule
